// ### mie_exec.sv
// Execute unit for far transfers, pointer loads, offset load, no-op,
// table lookup, byte reverse and exchange-with-add.
// Assumes a decoder presents one op at a time and a same-clock memory
// port that answers each request with a one-cycle valid.
// Notes on behaviour
// - A far pointer is a 16-bit selector plus a 32-bit offset.
// - Far transfers replace code selector; pointer is immediate or from memory.
// - Far call pushes code selector, then instruction pointer, before jumping.
// - Far return pops instruction pointer, then code selector, and resumes.
// - Data pointer load: memory far pointer to data selector and register.
// - Extra, F, G, stack loads act alike but hit their own selector.
// - Stack pointer load sets stack selector and pointer atomically, no shadow.
// - Pop into stack selector blocks interrupts for the next instruction.
// - Offset load writes computed operand offset without reading memory.
// - No-op is one byte, advances instruction pointer only.
// - Lookup reads byte at base plus unsigned low accumulator, replaces it.
// - Byte reverse works in place on a 32-bit register.
// - Byte 0 swaps with byte 3, byte 1 swaps with byte 2.
// - Exchange-with-add source is a register, destination register or memory.
// - Source gets old destination; destination gets the sum.
// - Flags follow the addition result.
// - Exchange-with-add honours lock so its memory update is atomic.
`timescale 1ns/1ps
`default_nettype none
module mie_exec
  import mie_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Decoded operation
  input wire logic op_valid_in,
  input wire logic [3:0] op_code_in,
  input wire logic [GPR_IDX_W-1:0] op_reg_in,
  input wire logic [GPR_IDX_W-1:0] op_src_reg_in,
  input wire logic op_dst_mem_in,
  input wire logic op_lock_in,
  input wire logic op_ptr_imm_in,
  input wire logic [SEL_W-1:0] imm_sel_in,
  input wire logic [OFS_W-1:0] imm_ofs_in,
  input wire logic [OFS_W-1:0] eff_addr_in,
  input wire logic [7:0] instr_len_in,
  // Memory port
  input wire logic mem_rvalid_in,
  input wire logic [DATA_W-1:0] mem_rdata_in,
  input wire logic mem_wdone_in,
  // Outputs
  output logic op_ready_out,
  output logic op_done_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic mem_lock_out,
  output logic [OFS_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_wdata_out,
  output logic [DATA_W-1:0] instr_pointer_out,
  output logic [SEL_W-1:0] code_segment_reg_out,
  output logic [SEL_W-1:0] data_segment_reg_out,
  output logic [SEL_W-1:0] extra_segment_reg_out,
  output logic [SEL_W-1:0] extra_segment_f_reg_out,
  output logic [SEL_W-1:0] extra_segment_g_reg_out,
  output logic [SEL_W-1:0] stack_segment_reg_out,
  output logic [FLAG_W-1:0] flags_out,
  output logic int_inhibit_out
);
  logic [DATA_W-1:0] gpr_ff [NUM_GPR];
  mie_state_e state_ff;
  mie_op_e op_ff;
  logic [GPR_IDX_W-1:0] reg_ff, src_ff;
  logic dst_mem_ff, lock_ff;
  logic [OFS_W-1:0] addr_ff;
  logic [OFS_W-1:0] ofs_ff;
  logic [DATA_W-1:0] tmp_ff;
  logic [7:0] len_ff;
  logic [DATA_W-1:0] sum_w, dst_w, src_w, swap_w;
  logic [DATA_W:0] sum_c;
  logic [OFS_W-1:0] ret_ip_w;

  // Far pointer halves are held in ofs_ff and the low bits of tmp_ff.
  assign ret_ip_w = instr_pointer_out + {24'h00_0000, len_ff};
  assign dst_w = dst_mem_ff ? tmp_ff : gpr_ff[reg_ff];
  assign src_w = gpr_ff[src_ff];
  assign sum_c = {1'b0, dst_w} + {1'b0, src_w};
  assign sum_w = sum_c[DATA_W-1:0];
  generate
    for (genvar b = 0; b < 4; b++) begin : g_swap
      assign swap_w[8*b +: 8] = gpr_ff[reg_ff][8*(3-b) +: 8];
    end
  endgenerate

  // Sequencer. Memory steps wait on the port, so a slow memory stalls here.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff <= MIE_ST_IDLE;
      op_ff <= MIE_OP_NO_OP;
      reg_ff <= '0;
      src_ff <= '0;
      dst_mem_ff <= 1'b0;
      lock_ff <= 1'b0;
      addr_ff <= ZERO_WORD;
      ofs_ff <= ZERO_WORD;
      tmp_ff <= ZERO_WORD;
      len_ff <= NO_OP_LEN;
    end else begin
      case (state_ff)
        MIE_ST_IDLE: begin
          // The op still offered beside its done pulse is the finished one.
          if (op_valid_in && !op_done_out) begin
            op_ff <= mie_op_e'(op_code_in);
            reg_ff <= op_reg_in;
            src_ff <= op_src_reg_in;
            dst_mem_ff <= op_dst_mem_in;
            lock_ff <= op_lock_in;
            len_ff <= instr_len_in;
            ofs_ff <= imm_ofs_in;
            tmp_ff <= {16'h0000, imm_sel_in};
            addr_ff <= eff_addr_in;
            case (mie_op_e'(op_code_in))
              MIE_OP_JMP_FAR, MIE_OP_CALL_FAR: begin
                state_ff <= op_ptr_imm_in ? MIE_ST_EXEC : MIE_ST_RD0;
              end
              MIE_OP_RET_FAR: begin
                addr_ff <= gpr_ff[GPR_STACK];
                state_ff <= MIE_ST_RD0;
              end
              MIE_OP_LDPTR_DATA, MIE_OP_LDPTR_EXTRA, MIE_OP_LDPTR_F,
              MIE_OP_LDPTR_G, MIE_OP_LDPTR_STACK: begin
                state_ff <= MIE_ST_RD0;
              end
              MIE_OP_POP_SS: begin
                addr_ff <= gpr_ff[GPR_STACK];
                state_ff <= MIE_ST_RD1;
              end
              MIE_OP_XLAT: begin
                addr_ff <= gpr_ff[GPR_BASE] +
                  {24'h00_0000, gpr_ff[GPR_ACC][7:0]};
                state_ff <= MIE_ST_RD1;
              end
              MIE_OP_XCHG_SUM: begin
                state_ff <= op_dst_mem_in ? MIE_ST_RD1 : MIE_ST_EXEC;
              end
              default: state_ff <= MIE_ST_EXEC;
            endcase
          end
        end
        MIE_ST_RD0: begin
          if (mem_rvalid_in) begin
            ofs_ff <= mem_rdata_in;
            addr_ff <= addr_ff + WORD_STEP;
            state_ff <= MIE_ST_RD1;
          end
        end
        MIE_ST_RD1: begin
          if (mem_rvalid_in) begin
            tmp_ff <= mem_rdata_in;
            state_ff <= MIE_ST_EXEC;
          end
        end
        MIE_ST_EXEC: begin
          if (op_ff == MIE_OP_CALL_FAR) begin
            // Selector goes first, zero-extended, then the pointer.
            addr_ff <= gpr_ff[GPR_STACK] - WORD_STEP;
            state_ff <= MIE_ST_WR0;
          end else if (op_ff == MIE_OP_XCHG_SUM && dst_mem_ff) begin
            state_ff <= MIE_ST_WR1;
          end else begin
            state_ff <= MIE_ST_DONE;
          end
        end
        MIE_ST_WR0: begin
          if (mem_wdone_in) begin
            addr_ff <= addr_ff - WORD_STEP;
            state_ff <= MIE_ST_WR1;
          end
        end
        MIE_ST_WR1: begin
          if (mem_wdone_in) begin
            state_ff <= MIE_ST_DONE;
          end
        end
        MIE_ST_DONE: state_ff <= MIE_ST_IDLE;
        default: state_ff <= MIE_ST_IDLE;
      endcase
    end
  end

  // Memory port drive. Lock covers the read and the write back.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_lock_out <= 1'b0;
      mem_addr_out <= ZERO_WORD;
      mem_wdata_out <= ZERO_WORD;
    end else begin
      mem_rd_out <= (state_ff == MIE_ST_RD0 || state_ff == MIE_ST_RD1) &&
        !mem_rvalid_in;
      mem_wr_out <= (state_ff == MIE_ST_WR0 || state_ff == MIE_ST_WR1) &&
        !mem_wdone_in;
      mem_lock_out <= lock_ff && op_ff == MIE_OP_XCHG_SUM && dst_mem_ff &&
        state_ff != MIE_ST_IDLE && state_ff != MIE_ST_DONE;
      mem_addr_out <= addr_ff;
      if (state_ff == MIE_ST_WR0) begin
        mem_wdata_out <= {16'h0000, code_segment_reg_out};
      end else if (op_ff == MIE_OP_CALL_FAR) begin
        mem_wdata_out <= ret_ip_w;
      end else if (state_ff == MIE_ST_EXEC) begin
        // Latched here: the source register is overwritten on this edge.
        mem_wdata_out <= sum_w;
      end
    end
  end

  // Register file and architectural state, updated at the exec step; a far call loads code selector and pointer at the second push.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_GPR; i++) begin
        gpr_ff[i] <= ZERO_WORD;
      end
      instr_pointer_out <= IP_RESET;
      code_segment_reg_out <= SEL_RESET;
      data_segment_reg_out <= SEL_RESET;
      extra_segment_reg_out <= SEL_RESET;
      extra_segment_f_reg_out <= SEL_RESET;
      extra_segment_g_reg_out <= SEL_RESET;
      stack_segment_reg_out <= SEL_RESET;
      flags_out <= '0;
    end else if (state_ff == MIE_ST_EXEC) begin
      if (op_ff != MIE_OP_CALL_FAR) begin
        instr_pointer_out <= ret_ip_w;
      end
      case (op_ff)
        MIE_OP_JMP_FAR: begin
          code_segment_reg_out <= tmp_ff[SEL_W-1:0];
          instr_pointer_out <= ofs_ff;
        end
        MIE_OP_CALL_FAR: begin
          gpr_ff[GPR_STACK] <= gpr_ff[GPR_STACK] - WORD_STEP - WORD_STEP;
        end
        MIE_OP_RET_FAR: begin
          instr_pointer_out <= ofs_ff;
          code_segment_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[GPR_STACK] <= gpr_ff[GPR_STACK] + WORD_STEP + WORD_STEP;
        end
        MIE_OP_LDPTR_DATA: begin
          data_segment_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[reg_ff] <= ofs_ff;
        end
        MIE_OP_LDPTR_EXTRA: begin
          extra_segment_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[reg_ff] <= ofs_ff;
        end
        MIE_OP_LDPTR_F: begin
          extra_segment_f_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[reg_ff] <= ofs_ff;
        end
        MIE_OP_LDPTR_G: begin
          extra_segment_g_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[reg_ff] <= ofs_ff;
        end
        MIE_OP_LDPTR_STACK: begin
          // Both halves land on the same edge, so no interrupt fits between.
          stack_segment_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[reg_ff] <= ofs_ff;
        end
        MIE_OP_POP_SS: begin
          stack_segment_reg_out <= tmp_ff[SEL_W-1:0];
          gpr_ff[GPR_STACK] <= gpr_ff[GPR_STACK] + WORD_STEP;
        end
        MIE_OP_EFF_OFS: gpr_ff[reg_ff] <= addr_ff;
        MIE_OP_XLAT: gpr_ff[GPR_ACC][7:0] <= tmp_ff[7:0];
        MIE_OP_BSWAP: gpr_ff[reg_ff] <= swap_w;
        MIE_OP_XCHG_SUM: begin
          gpr_ff[src_ff] <= dst_w;
          if (!dst_mem_ff) begin
            gpr_ff[reg_ff] <= sum_w;
          end
          flags_out[FLAG_CF] <= sum_c[DATA_W];
          flags_out[FLAG_ZF] <= (sum_w == ZERO_WORD);
          flags_out[FLAG_SF] <= sum_w[DATA_W-1];
          flags_out[FLAG_PF] <= ~^sum_w[7:0];
          flags_out[FLAG_AF] <= dst_w[4] ^ src_w[4] ^ sum_w[4];
          flags_out[FLAG_OF] <= (dst_w[DATA_W-1] == src_w[DATA_W-1]) &&
            (sum_w[DATA_W-1] != dst_w[DATA_W-1]);
        end
        default: ;
      endcase
    end else if (state_ff == MIE_ST_WR1 && mem_wdone_in &&
                 op_ff == MIE_OP_CALL_FAR) begin
      code_segment_reg_out <= tmp_ff[SEL_W-1:0];
      instr_pointer_out <= ofs_ff;
    end
  end

  // Interrupt shadow: only a pop into the stack selector raises it.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      int_inhibit_out <= 1'b0;
      op_done_out <= 1'b0;
      op_ready_out <= 1'b0;
    end else begin
      op_done_out <= (state_ff == MIE_ST_DONE);
      op_ready_out <= (state_ff == MIE_ST_IDLE) && !op_valid_in;
      if (state_ff == MIE_ST_EXEC) begin
        int_inhibit_out <= (op_ff == MIE_OP_POP_SS);
      end else if (state_ff == MIE_ST_IDLE && op_valid_in) begin
        int_inhibit_out <= int_inhibit_out;
      end
      if (state_ff == MIE_ST_DONE && op_ff != MIE_OP_POP_SS &&
          int_inhibit_out) begin
        int_inhibit_out <= 1'b0;
      end
    end
  end
endmodule : mie_exec
`default_nettype wire

// ### mie_pkg.sv
// Package for the miscellaneous instruction execute unit.
// Assumes one core clock domain; the unit is driven by a decoder.
package mie_pkg;
  localparam int SEL_W = 16;
  localparam int OFS_W = 32;
  localparam int DATA_W = 32;
  localparam int GPR_IDX_W = 3;
  localparam int NUM_GPR = 8;
  localparam int FLAG_W = 6;
  // Flag positions inside the arithmetic flag vector.
  localparam int FLAG_CF = 0;
  localparam int FLAG_PF = 1;
  localparam int FLAG_AF = 2;
  localparam int FLAG_ZF = 3;
  localparam int FLAG_SF = 4;
  localparam int FLAG_OF = 5;
  // Fixed register indices.
  localparam logic [2:0] GPR_ACC = 3'h0;
  localparam logic [2:0] GPR_BASE = 3'h3;
  localparam logic [2:0] GPR_STACK = 3'h4;
  localparam logic [7:0] NO_OP_LEN = 8'h01;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [31:0] IP_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    MIE_OP_NO_OP = 4'h0,
    MIE_OP_JMP_FAR = 4'h1,
    MIE_OP_CALL_FAR = 4'h2,
    MIE_OP_RET_FAR = 4'h3,
    MIE_OP_LDPTR_DATA = 4'h4,
    MIE_OP_LDPTR_EXTRA = 4'h5,
    MIE_OP_LDPTR_F = 4'h6,
    MIE_OP_LDPTR_G = 4'h7,
    MIE_OP_LDPTR_STACK = 4'h8,
    MIE_OP_EFF_OFS = 4'h9,
    MIE_OP_XLAT = 4'ha,
    MIE_OP_BSWAP = 4'hb,
    MIE_OP_XCHG_SUM = 4'hc,
    MIE_OP_POP_SS = 4'hd
  } mie_op_e;

  typedef enum logic [6:0] {
    MIE_ST_IDLE = 7'b000_0001,
    MIE_ST_RD0 = 7'b000_0010,
    MIE_ST_RD1 = 7'b000_0100,
    MIE_ST_WR0 = 7'b000_1000,
    MIE_ST_WR1 = 7'b001_0000,
    MIE_ST_EXEC = 7'b010_0000,
    MIE_ST_DONE = 7'b100_0000
  } mie_state_e;
endpackage : mie_pkg

// ### mie_exec_chk.sv
// Port checker for the miscellaneous instruction execute unit.
// Assumes one clock domain and an op held until its done pulse.
`timescale 1ns/1ps
`default_nettype none
module mie_exec_chk
  import mie_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Op inputs
  input wire logic op_valid_in,
  input wire logic [3:0] op_code_in,
  input wire logic op_lock_in,
  input wire logic op_dst_mem_in,
  // Memory port
  input wire logic mem_rvalid_in,
  input wire logic mem_wdone_in,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic mem_lock_out,
  input wire logic [OFS_W-1:0] mem_addr_out,
  input wire logic [DATA_W-1:0] mem_wdata_out,
  // State outputs
  input wire logic op_done_out,
  input wire logic [SEL_W-1:0] code_segment_reg_out,
  input wire logic [SEL_W-1:0] data_segment_reg_out,
  input wire logic [FLAG_W-1:0] flags_out,
  input wire logic int_inhibit_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_rd_held: assert property (mem_rd_out && !mem_rvalid_in
    |=> mem_rd_out && $stable(mem_addr_out)) else $error("read dropped");
  a_wr_held: assert property (mem_wr_out && !mem_wdone_in
    |=> mem_wr_out && $stable(mem_wdata_out)) else $error("write dropped");
  a_lock_only_xsum: assert property (mem_lock_out |-> op_lock_in
    && op_dst_mem_in && op_code_in == MIE_OP_XCHG_SUM)
    else $error("bad lock");
  a_lock_on_wr: assert property (mem_wr_out && op_lock_in
    && op_code_in == MIE_OP_XCHG_SUM |-> mem_lock_out)
    else $error("no lock");
  a_idle_op_quiet: assert property (op_valid_in
    && op_code_in == MIE_OP_NO_OP |-> !mem_rd_out && !mem_wr_out
    ##1 $stable(flags_out) && $stable(code_segment_reg_out))
    else $error("no-op changed state");
  a_no_mem_use: assert property (op_valid_in && op_code_in inside
    {MIE_OP_EFF_OFS, MIE_OP_BSWAP} |-> !mem_rd_out && !mem_wr_out)
    else $error("memory used");
  a_cs_far_only: assert property (!$stable(code_segment_reg_out)
    |-> $past(op_code_in) inside {MIE_OP_JMP_FAR, MIE_OP_CALL_FAR,
    MIE_OP_RET_FAR}) else $error("code selector changed");
  a_data_sel_only: assert property (!$stable(data_segment_reg_out)
    |-> $past(op_code_in) == MIE_OP_LDPTR_DATA)
    else $error("data selector changed");
  a_shadow_src: assert property ($rose(int_inhibit_out)
    |-> $past(op_code_in) == MIE_OP_POP_SS) else $error("bad inhibit");
  a_flags_src: assert property (!$stable(flags_out)
    |-> $past(op_code_in) == MIE_OP_XCHG_SUM) else $error("flags changed");
  a_bswap_time: assert property ($rose(op_valid_in)
    && op_code_in == MIE_OP_BSWAP |-> ##3 op_done_out) else $error("late");
endmodule : mie_exec_chk
bind mie_exec mie_exec_chk u_chk (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
  .op_lock_in(op_lock_in), .op_dst_mem_in(op_dst_mem_in),
  .mem_rvalid_in(mem_rvalid_in), .mem_wdone_in(mem_wdone_in),
  .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
  .mem_lock_out(mem_lock_out), .mem_addr_out(mem_addr_out),
  .mem_wdata_out(mem_wdata_out), .op_done_out(op_done_out),
  .code_segment_reg_out(code_segment_reg_out),
  .data_segment_reg_out(data_segment_reg_out),
  .flags_out(flags_out), .int_inhibit_out(int_inhibit_out));
`default_nettype wire

// ### mie_exec_tb_top.sv
// Self-checking bench for the execute unit with a word-wide memory.
// Assumes memory answers each request one cycle after it rises.
`timescale 1ns/1ps
`default_nettype none
module mie_exec_tb_top;
  import mie_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic v = 1'b0, pi = 1'b0, dm = 1'b0, lk = 1'b0, rv = 1'b0, wd = 1'b0;
  logic [3:0] oc = 4'h0;
  logic [2:0] rg = 3'h0, sr = 3'h0, r;
  logic [15:0] isel = 16'h0000;
  logic [31:0] iofs = 32'h0000_0000, ea = 32'h0000_0000;
  logic [31:0] rd = 32'h0000_0000;
  logic [7:0] ln = 8'h01;
  logic rdy, dn, mr, mw, ml, ii, mii;
  logic [31:0] ma, mwd, ip, exp_ip, t, u;
  logic [15:0] cs, seg_d, seg_e, seg_f, seg_g, ss;
  logic [15:0] m[6];
  logic [5:0] fl, mfl;
  logic [31:0] g[8];
  logic [31:0] qra[$], qwa[$], qwd[$];
  logic [31:0] mem[logic [31:0]];
  int err_total = 0, tests_run = 0, seed = 14917, i;

  mie_exec dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .op_valid_in(v), .op_code_in(oc), .op_reg_in(rg), .op_src_reg_in(sr),
    .op_dst_mem_in(dm), .op_lock_in(lk), .op_ptr_imm_in(pi),
    .imm_sel_in(isel), .imm_ofs_in(iofs), .eff_addr_in(ea),
    .instr_len_in(ln), .mem_rvalid_in(rv), .mem_rdata_in(rd),
    .mem_wdone_in(wd), .op_ready_out(rdy), .op_done_out(dn),
    .mem_rd_out(mr), .mem_wr_out(mw), .mem_lock_out(ml),
    .mem_addr_out(ma), .mem_wdata_out(mwd), .instr_pointer_out(ip),
    .code_segment_reg_out(cs), .data_segment_reg_out(seg_d),
    .extra_segment_reg_out(seg_e), .extra_segment_f_reg_out(seg_f),
    .extra_segment_g_reg_out(seg_g), .stack_segment_reg_out(ss),
    .flags_out(fl), .int_inhibit_out(ii));

  always #2.5 clk_sys_in = ~clk_sys_in;

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    tests_run++;
    if (a !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk

  function automatic logic [31:0] rdm(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : ~a;
  endfunction : rdm

  function automatic logic [5:0] addf(input logic [31:0] a, b);
    logic [32:0] s;
    logic [31:0] x;
    s = {1'b0, a} + {1'b0, b};
    x = a ^ b ^ s[31:0];
    return {a[31] == b[31] && s[31] != a[31], s[31], s[31:0] == 32'h0000_0000,
      x[4], ~^s[7:0], s[32]};
  endfunction : addf

  // Addresses are checked in order, so a swapped pointer fetch shows.
  always @(posedge clk_sys_in) begin
    rv <= 1'b0;
    wd <= 1'b0;
    if (mr && !rv) begin
      chk(ma, qra.size() != 0 ? qra.pop_front() : ~ma);
      rd <= rdm(ma);
      rv <= 1'b1;
    end
    if (mw && !wd) begin
      chk(ma, qwa.size() != 0 ? qwa.pop_front() : ~ma);
      chk(mwd, qwd.size() != 0 ? qwd.pop_front() : ~mwd);
      chk(ml, lk && oc == MIE_OP_XCHG_SUM);
      mem[ma] = mwd;
      wd <= 1'b1;
    end
  end

  task automatic op(input logic [3:0] c, input logic [2:0] d, s,
      input logic [31:0] a, input logic [2:0] f);
    int n;
    @(posedge clk_sys_in);
    oc <= c;
    rg <= d;
    sr <= s;
    ea <= a;
    {pi, dm, lk} <= f;
    ln <= (c == MIE_OP_NO_OP) ? NO_OP_LEN : 8'h03;
    v <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_sys_in);
      if (n == 0) chk(rdy, 32'h0000_0001);
      if (dn === 1'b1) break;
    end
    v <= 1'b0;
    if (n == 64) begin
      err_total++;
      end_of_test();
    end
  endtask : op

  task automatic cmp();
    chk(ip, exp_ip);
    chk(cs, m[0]);
    chk(seg_d, m[1]);
    chk(seg_e, m[2]);
    chk(seg_f, m[3]);
    chk(seg_g, m[4]);
    chk(ss, m[5]);
    chk(fl, mfl);
    chk(ii, mii);
    chk(qra.size() + qwa.size(), 0);
  endtask : cmp

  // The exchange to memory exposes a register that has no port of its own.
  task automatic xm(input logic [2:0] s, input logic l);
    logic [31:0] a, o;
    a = $random(seed) & 32'h00ff_fffc;
    o = rdm(a);
    qra.push_back(a);
    qwa.push_back(a);
    qwd.push_back(o + g[s]);
    op(MIE_OP_XCHG_SUM, 3'h0, s, a, {2'h1, l});
    mfl = addf(o, g[s]);
    g[s] = o;
    exp_ip += 3;
    cmp();
  endtask : xm

  task automatic zero();
    exp_ip = 32'h0000_0000;
    m = '{default: 16'h0000};
    mfl = 6'h00;
    mii = 1'b0;
  endtask : zero

  initial begin
    zero();
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    cmp(); // RESET
    for (i = 0; i < 8; i++) begin
      t = $random(seed);
      op(MIE_OP_EFF_OFS, i[2:0], 3'h0, t, 3'h0);
      g[i] = t;
      exp_ip += 3;
    end
    for (i = 1; i < 4; i++) begin
      op(MIE_OP_BSWAP, i[2:0], 3'h0, 32'h0000_0000, 3'h0);
      g[i] = {g[i][7:0], g[i][15:8], g[i][23:16], g[i][31:24]};
      op(MIE_OP_XCHG_SUM, i[2:0] + 3'h1, i[2:0], 32'h0000_0000, 3'h0);
      t = g[i+1];
      mfl = addf(t, g[i]);
      g[i+1] = t + g[i];
      g[i] = t;
      exp_ip += 6;
      xm(i[2:0], i[0]);
      xm(i[2:0] + 3'h1, 1'b1);
    end
    $display("test swap and exchange done");
    t = g[3] + {24'h00_0000, g[0][7:0]};
    qra.push_back(t);
    op(MIE_OP_XLAT, 3'h0, 3'h0, 32'h0000_0000, 3'h0);
    u = rdm(t);
    g[0][7:0] = u[7:0];
    exp_ip += 3;
    xm(3'h0, 1'b0);
    $display("test lookup done");
    for (i = 4; i < 9; i++) begin
      t = $random(seed) & 32'h00ff_fff0;
      r = (i == 8) ? 3'h4 : i[2:0] - 3'h3;
      qra.push_back(t);
      qra.push_back(t + 32'h0000_0004);
      op(i[3:0], r, 3'h0, t, 3'h0);
      u = rdm(t + 32'h0000_0004);
      m[i-3] = u[15:0];
      g[r] = rdm(t);
      exp_ip += 3;
      cmp();
    end
    xm(3'h1, 1'b0);
    $display("test pointer loads done");
    t = $random(seed);
    isel <= t[15:0] ^ 16'ha5a5;
    iofs <= t;
    op(MIE_OP_JMP_FAR, 3'h0, 3'h0, 32'h0000_0000, 3'h4);
    m[0] = t[15:0] ^ 16'ha5a5;
    exp_ip = t;
    cmp();
    t = 32'h0001_0000;
    qra.push_back(t);
    qra.push_back(t + 32'h0000_0004);
    op(MIE_OP_JMP_FAR, 3'h0, 3'h0, t, 3'h0);
    exp_ip = rdm(t);
    u = rdm(t + 32'h0000_0004);
    m[0] = u[15:0];
    cmp();
    t = $random(seed);
    isel <= t[31:16];
    iofs <= t;
    qwa.push_back(g[4] - 32'h0000_0004);
    qwd.push_back({16'h0000, m[0]});
    qwa.push_back(g[4] - 32'h0000_0008);
    qwd.push_back(exp_ip + 32'h0000_0003);
    op(MIE_OP_CALL_FAR, 3'h0, 3'h0, 32'h0000_0000, 3'h4);
    g[4] -= 8;
    exp_ip = t;
    m[0] = t[31:16];
    cmp();
    qra.push_back(g[4]);
    qra.push_back(g[4] + 32'h0000_0004);
    op(MIE_OP_RET_FAR, 3'h0, 3'h0, 32'h0000_0000, 3'h0);
    exp_ip = rdm(g[4]);
    u = rdm(g[4] + 32'h0000_0004);
    m[0] = u[15:0];
    g[4] += 8;
    cmp();
    qra.push_back(g[4]);
    op(MIE_OP_POP_SS, 3'h0, 3'h0, 32'h0000_0000, 3'h0);
    u = rdm(g[4]);
    m[5] = u[15:0];
    g[4] += 4;
    exp_ip += 3;
    mii = 1'b1;
    cmp();
    op(MIE_OP_NO_OP, 3'h0, 3'h0, 32'h0000_0000, 3'h0);
    exp_ip += 1;
    mii = 1'b0;
    cmp();
    $display("test far transfers done");
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    zero();
    cmp(); // RESET
    $display("test second reset done");
    end_of_test();
  end
endmodule : mie_exec_tb_top
`default_nettype wire
